/* msc_dir_decode.sv */
// Decodes the security mode into per-direction region controls.
// Assumes inputs come from registers on the same clock.
`timescale 1ns/10ps
module msc_dir_decode (
    // Configuration in
    input  wire logic       key_second,
    input  wire logic [1:0] mode,
    input  wire logic [6:0] aux_length,
    // Decoded controls
    output msc_pkg::msc_dir_cfg_s cfg
);

    // Meaning of the aux length per mode
    always_comb begin
        cfg            = '0;
        cfg.key_second = key_second;
        cfg.aux_length = aux_length;
        unique case (msc_pkg::msc_mode_e'(mode))
            msc_pkg::MODE_NONE: begin
                cfg.aux_length = 7'h00;
            end
            msc_pkg::MODE_CBC_MAC: begin
                cfg.auth_on = 1'b1; // R5
            end
            msc_pkg::MODE_CTR: begin
                cfg.cipher_on = 1'b1; // R4
            end
            msc_pkg::MODE_CCM: begin
                cfg.auth_on   = 1'b1;
                cfg.cipher_on = 1'b1;
                cfg.auth_only = 1'b1; // R6 R8
            end
        endcase
    end

endmodule

/* msc_pkg.sv */
// Package for the MAC security configuration block.
// Assumes 32-bit AXI4-Lite access and one clock domain.
package msc_pkg;

    // ****************************************************************
    // Register indices and address width
    // ****************************************************************
    localparam logic [15:0] SECURITY_CONTROL_IDX    = 16'h2193;
    localparam logic [15:0] TX_AUXILIARY_LENGTH_IDX = 16'h2194;
    localparam logic [15:0] RX_AUXILIARY_LENGTH_IDX = 16'h2195;
    localparam logic [15:0] STANDALONE_RUN_IDX      = 16'h218E;
    localparam int          ADDR_W                  = 18;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         STANDALONE_KEY_SELECT_BIT = 7;
    localparam int         TRANSMIT_KEY_SELECT_BIT   = 6;
    localparam int         RECEIVE_KEY_SELECT_BIT    = 5;
    localparam int         TAGLEN_LSB                = 2;
    localparam int         MODE_LSB                  = 0;
    localparam int         RUN_BIT                   = 0;
    localparam int         AUXLEN_W                  = 7;
    localparam logic [7:0] SEC_RESET                 = 8'h00;
    localparam logic [6:0] AUX_RESET                 = 7'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Security modes
    typedef enum logic [1:0] {
        MODE_NONE    = 2'b00,
        MODE_CBC_MAC = 2'b01,
        MODE_CTR     = 2'b10,
        MODE_CCM     = 2'b11
    } msc_mode_e;

    // Per-direction region description for the engine
    typedef struct packed {
        logic       key_second;   // Second key selected
        logic [6:0] aux_length;   // Bytes before region of interest
        logic       auth_only;    // CCM: aux bytes authenticated only
        logic       cipher_on;    // CTR or CCM: encrypt or decrypt
        logic       auth_on;      // CBC-MAC or CCM: authenticate
    } msc_dir_cfg_s;

    // Full block state
    typedef struct packed {
        logic [7:0]  sec;
        logic [6:0]  tx_aux;
        logic [6:0]  rx_aux;
        logic        aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        run_pulse;
        logic        run_key_second;
        msc_dir_cfg_s tx_cfg;
        msc_dir_cfg_s rx_cfg;
    } msc_state_s;

endpackage

/* msc_security_config.sv */
// Security configuration registers of a packet MAC's AES engine.
// Assumes an AXI4-Lite master on aclk and an engine that reads the
// decoded controls every cycle.
`timescale 1ns/10ps

// Functional notes
// R1: Standalone key select bit 7 picks the second key when set, the first when clear.
// R2: Transmit key select bit 6 picks the key used during transmission the same way.
// R3: Transmit aux length is seven bits 6:0, bit 7 reserved, reset zero.
// R4: In CTR mode the aux length counts bytes from length byte to first ciphered byte.
// R5: In CBC-MAC mode the aux length counts bytes from length byte to first authenticated byte.
// R6: In CCM mode the transmit aux length counts bytes authenticated but not ciphered.
// R7: Receive aux length is seven bits 6:0 with the same per-mode meaning, bit 7 reserved.
// R8: In CCM mode the receive aux length counts bytes authenticated but not decrypted.
// R9: Security mode bits 1:0 select none, CBC-MAC, CTR or CCM, reset zero.
// R10: Writing one to the run bit starts a standalone run with the chosen key and self-clears.
module msc_security_config (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Engine controls
    output logic [1:0]       security_mode_select,
    output logic [2:0]       auth_tag_length,
    output logic             receive_key_select,
    output logic             standalone_cipher_run,
    output logic             standalone_key_select,
    output msc_pkg::msc_dir_cfg_s tx_cfg,
    output msc_pkg::msc_dir_cfg_s rx_cfg
);

    // ****************************************************************
    // State
    // ****************************************************************
    msc_pkg::msc_state_s   state_reg;
    msc_pkg::msc_state_s   state_next;
    msc_pkg::msc_dir_cfg_s tx_dec;
    msc_pkg::msc_dir_cfg_s rx_dec;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    // Indices count 32-bit words, so each index is shifted up by two bits to a byte address
    // Upper address bits are ignored, so the map repeats above them
    localparam logic [msc_pkg::ADDR_W-1:0] SEC_ADDR =
        {msc_pkg::SECURITY_CONTROL_IDX, 2'b00};
    localparam logic [msc_pkg::ADDR_W-1:0] TXAUX_ADDR =
        {msc_pkg::TX_AUXILIARY_LENGTH_IDX, 2'b00};
    localparam logic [msc_pkg::ADDR_W-1:0] RXAUX_ADDR =
        {msc_pkg::RX_AUXILIARY_LENGTH_IDX, 2'b00};
    localparam logic [msc_pkg::ADDR_W-1:0] RUN_ADDR =
        {msc_pkg::STANDALONE_RUN_IDX, 2'b00};

    // ****************************************************************
    // Mode decode per direction
    // ****************************************************************
    // Transmit side takes its key from bit 6
    msc_dir_decode u_tx_dec (
        .key_second (state_reg.sec[msc_pkg::TRANSMIT_KEY_SELECT_BIT]),
        .mode       (state_reg.sec[msc_pkg::MODE_LSB +: 2]),
        .aux_length (state_reg.tx_aux),
        .cfg        (tx_dec)
    );

    // Receive side takes its key from bit 5
    msc_dir_decode u_rx_dec (
        .key_second (state_reg.sec[msc_pkg::RECEIVE_KEY_SELECT_BIT]),
        .mode       (state_reg.sec[msc_pkg::MODE_LSB +: 2]),
        .aux_length (state_reg.rx_aux),
        .cfg        (rx_dec)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Handshake qualifiers for this cycle
    logic                      do_write;
    logic                      rd_take;
    logic [msc_pkg::ADDR_W-1:0] rd_addr;

    // Hold all state; the run pulse lasts one cycle only
    always_comb begin
        state_next           = state_reg;
        state_next.run_pulse = 1'b0;
        do_write = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
        rd_take  = s_axi_arvalid && !state_reg.rvalid;
        rd_addr  = {s_axi_araddr[msc_pkg::ADDR_W-1:2], 2'b00};

        // Capture address and data in either order
        if (s_axi_awvalid && !state_reg.aw_full) begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = {s_axi_awaddr[msc_pkg::ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && !state_reg.w_full) begin
            state_next.w_full = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        // Register write once both halves are held
        if (do_write) begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = msc_pkg::RESP_OKAY;
            // Only the low byte lane carries register data
            if (state_reg.aw_addr == SEC_ADDR) begin
                if (state_reg.w_strb[0]) begin
                    state_next.sec = state_reg.w_data[7:0]; // R1 R2 R9
                end
            end else if (state_reg.aw_addr == TXAUX_ADDR) begin
                if (state_reg.w_strb[0]) begin
                    state_next.tx_aux = state_reg.w_data[6:0]; // R3
                end
            end else if (state_reg.aw_addr == RXAUX_ADDR) begin
                if (state_reg.w_strb[0]) begin
                    state_next.rx_aux = state_reg.w_data[6:0]; // R7
                end
            end else if (state_reg.aw_addr == RUN_ADDR) begin
                if (state_reg.w_strb[0] && state_reg.w_data[msc_pkg::RUN_BIT]) begin
                    state_next.run_pulse      = 1'b1; // R10
                    // Key frozen with the pulse; a later bit 7 write cannot alter it
                    state_next.run_key_second =
                        state_reg.sec[msc_pkg::STANDALONE_KEY_SELECT_BIT]; // R1
                end
            end else begin
                state_next.bresp = msc_pkg::RESP_SLVERR;
            end
        end

        // Response leaves once the master takes it
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read decode; run register reads as zero
        if (rd_take) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = msc_pkg::RESP_OKAY;
            state_next.rdata  = 32'h0000_0000;
            // Unused and reserved bits stay zero
            if (rd_addr == SEC_ADDR) begin
                state_next.rdata[7:0] = state_reg.sec;
            end else if (rd_addr == TXAUX_ADDR) begin
                state_next.rdata[6:0] = state_reg.tx_aux; // R3
            end else if (rd_addr == RXAUX_ADDR) begin
                state_next.rdata[6:0] = state_reg.rx_aux; // R7
            end else if (rd_addr != RUN_ADDR) begin
                state_next.rresp = msc_pkg::RESP_SLVERR;
            end
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // Registered engine controls
        state_next.tx_cfg = tx_dec; // R2 R4 R5 R6
        state_next.rx_cfg = rx_dec; // R8
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Synchronous reset to the power-on values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg        <= '0;
            state_reg.sec    <= msc_pkg::SEC_RESET; // R9
            state_reg.tx_aux <= msc_pkg::AUX_RESET;
            state_reg.rx_aux <= msc_pkg::AUX_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs straight from flip-flops
    // ****************************************************************
    // Write channel handshake
    assign s_axi_awready         = !state_reg.aw_full;
    assign s_axi_wready          = !state_reg.w_full;
    assign s_axi_bvalid          = state_reg.bvalid;
    assign s_axi_bresp           = state_reg.bresp;

    // Read channel handshake and data
    assign s_axi_arready         = !state_reg.rvalid;
    assign s_axi_rvalid          = state_reg.rvalid;
    assign s_axi_rdata           = state_reg.rdata;
    assign s_axi_rresp           = state_reg.rresp;

    // Security register fields
    assign security_mode_select  = state_reg.sec[msc_pkg::MODE_LSB +: 2];
    assign auth_tag_length       = state_reg.sec[msc_pkg::TAGLEN_LSB +: 3];
    assign receive_key_select    = state_reg.sec[msc_pkg::RECEIVE_KEY_SELECT_BIT];

    // Standalone run pulse and its key
    assign standalone_cipher_run = state_reg.run_pulse;
    assign standalone_key_select = state_reg.run_key_second;

    // Decoded per-direction controls
    assign tx_cfg                = state_reg.tx_cfg;
    assign rx_cfg                = state_reg.rx_cfg;

endmodule

/* msc_security_config_monitor.sv */
// Port assertions for the security configuration block.
// Assumes one clock and binding onto msc_security_config.
`timescale 1ns/10ps
module msc_monitor (
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Bus
    input wire logic                  s_axi_bvalid,
    // Engine controls
    input wire logic [1:0]            security_mode_select,
    input wire logic                  standalone_cipher_run,
    input wire msc_pkg::msc_dir_cfg_s tx_cfg,
    input wire msc_pkg::msc_dir_cfg_s rx_cfg
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // Run pulse and decoded controls
    // ****
    sequence s_run; standalone_cipher_run; endsequence
    sequence s_held; $stable(security_mode_select); endsequence
    property p_run_pulse; s_run |=> !standalone_cipher_run; endproperty
    property p_run_resp; s_run |-> s_axi_bvalid; endproperty
    property p_cipher; s_held |-> tx_cfg.cipher_on == security_mode_select[1]; endproperty
    property p_auth; s_held |-> tx_cfg.auth_on == security_mode_select[0]; endproperty
    property p_tx_ccm; s_held |-> tx_cfg.auth_only == (security_mode_select == 2'h3); endproperty
    property p_rx_ccm; s_held |-> rx_cfg.auth_only == (security_mode_select == 2'h3); endproperty
    property p_rx_mode; s_held |-> {rx_cfg.cipher_on, rx_cfg.auth_on} == security_mode_select;
    endproperty
    property p_none; s_held ##0 (security_mode_select == 2'h0) |->
        tx_cfg.aux_length == 7'h00 && rx_cfg.aux_length == 7'h00; endproperty
    a_run_pulse: assert property (p_run_pulse) else $error("run pulse too long");
    a_run_resp: assert property (p_run_resp) else $error("run without response");
    a_cipher: assert property (p_cipher) else $error("cipher flag wrong");
    a_auth: assert property (p_auth) else $error("auth flag wrong");
    a_tx_ccm: assert property (p_tx_ccm) else $error("tx auth only wrong");
    a_rx_ccm: assert property (p_rx_ccm) else $error("rx auth only wrong");
    a_rx_mode: assert property (p_rx_mode) else $error("rx flags wrong");
    a_none: assert property (p_none) else $error("aux length not cleared");
endmodule
bind msc_security_config msc_monitor i_mon (.aclk, .aresetn, .s_axi_bvalid,
    .security_mode_select, .standalone_cipher_run, .tx_cfg, .rx_cfg);

/* msc_security_config_tb.sv */
// Testbench for the security configuration block.
// Assumes the design answers AXI4-Lite requests by handshake.
`timescale 1ns/10ps
module msc_security_config_tb;
    localparam logic [15:0] SEC = msc_pkg::SECURITY_CONTROL_IDX;
    localparam logic [15:0] TXA = msc_pkg::TX_AUXILIARY_LENGTH_IDX;
    localparam logic [15:0] RXA = msc_pkg::RX_AUXILIARY_LENGTH_IDX;
    localparam logic [15:0] RUN = msc_pkg::STANDALONE_RUN_IDX;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, receive_key_select, standalone_cipher_run;
    logic        standalone_key_select, run_seen;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, security_mode_select, resp;
    logic [2:0]  auth_tag_length;
    logic [7:0]  secv [4] = '{8'h89, 8'h40, 8'h66, 8'hFF};
    int          error_cnt, cmp_count;
    msc_pkg::msc_dir_cfg_s tx_cfg, rx_cfg;
    msc_security_config i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .security_mode_select, .auth_tag_length, .receive_key_select,
        .standalone_cipher_run, .standalone_key_select, .tx_cfg, .rx_cfg);
    // Clock generator
    always #12.5 aclk = ~aclk;
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= {14'h0000, idx, 2'b00};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        run_seen = standalone_cipher_run;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk(32'(resp), 32'(er));
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= {14'h0000, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (er == msc_pkg::RESP_OKAY) chk(got, e);
        chk(32'(resp), 32'(er));
    endtask
    task automatic cfg_chk(input logic [7:0] s, input logic [6:0] ta, input logic [6:0] ra);
        logic [1:0] m;
        m = s[1:0];
        chk(32'(security_mode_select), 32'(m));
        chk(32'(auth_tag_length), 32'(s[4:2]));
        chk(32'(receive_key_select), 32'(s[5]));
        chk(32'(tx_cfg), 32'({s[6], (m == 2'h0) ? 7'h00 : ta, m == 2'h3, m[1], m[0]}));
        chk(32'(rx_cfg), 32'({s[5], (m == 2'h0) ? 7'h00 : ra, m == 2'h3, m[1], m[0]}));
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****
    // Test sequence
    // ****
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        error_cnt = 0;
        cmp_count = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SEC, 32'h00, msc_pkg::RESP_OKAY);
        rd(TXA, 32'h00, msc_pkg::RESP_OKAY);
        rd(RXA, 32'h00, msc_pkg::RESP_OKAY);
        wr(TXA, 8'hFF, msc_pkg::RESP_OKAY);
        rd(TXA, 32'h7F, msc_pkg::RESP_OKAY);
        wr(RXA, 8'hAA, msc_pkg::RESP_OKAY);
        rd(RXA, 32'h2A, msc_pkg::RESP_OKAY);
        // Every mode, both key choices, then a standalone run
        foreach (secv[i]) begin
            wr(SEC, secv[i], msc_pkg::RESP_OKAY);
            rd(SEC, {24'h000000, secv[i]}, msc_pkg::RESP_OKAY);
            cfg_chk(secv[i], 7'h7F, 7'h2A);
            wr(RUN, 8'h01, msc_pkg::RESP_OKAY);
            chk(32'(run_seen), 32'h1);
            chk(32'(standalone_key_select), 32'(secv[i][7]));
        end
        wr(RUN, 8'h00, msc_pkg::RESP_OKAY);
        chk(32'(run_seen), 32'h0);
        rd(RUN, 32'h00, msc_pkg::RESP_OKAY);
        // Unmapped place refused without effect
        wr(16'h2196, 8'h55, msc_pkg::RESP_SLVERR);
        rd(16'h2196, 32'h00, msc_pkg::RESP_SLVERR);
        // Write with the low byte lane off leaves the register alone
        s_axi_wstrb <= 4'hE;
        wr(SEC, 8'h00, msc_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(SEC, 32'hFF, msc_pkg::RESP_OKAY);
        conclude();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge aclk);
        error_cnt++;
        conclude();
    end
endmodule
